// ---- design/osc_clk_mux.v ----
/*
 source selection and gating of the system and sub clock enables.
 assumes all inputs are register levels on pclk; outputs are combinational.
*/
`timescale 1ns/1ps
module osc_clk_mux (
   input wire slow_source_select,
   input wire fast_source_select,
   input wire [2:0] div_sel,
   input wire fhiden,
   input wire fsiden,
   input wire halt,
   input wire lxt_ready,
   output wire [1:0] sub_src,
   output wire [1:0] fast_src,
   output wire sys_run,
   output wire sub_run,
   output wire fast_run
);
   // 01 slow rc, 10 slow crystal
   assign sub_src = slow_source_select ? 2'h2 : 2'h1;
   // 01 fast rc, 10 fast crystal
   assign fast_src = fast_source_select ? 2'h2 : 2'h1;
   assign sys_run = !halt && (div_sel != 3'h7 || !slow_source_select || lxt_ready);
   assign sub_run = !halt || fsiden;
   assign fast_run = !halt || fhiden;
endmodule // osc_clk_mux

// ---- design/osc_defs.vh ----
/*
 constants for the oscillator source control block: register offsets,
 field positions, reset values and start-up counts.
 assumes a 100 MHz pclk and an APB slave with 32-bit data.
*/
`ifndef OSC_DEFS_VH
`define OSC_DEFS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OSC_SYSTEM_CLOCK_CTRL_OFF 12'h000
`define OSC_FAST_RC_CTRL_OFF 12'h004
`define OSC_SLOW_XTAL_CTRL_OFF 12'h008
`define OSC_PIN_SHARE_OFF 12'h00C
`define OSC_STATUS_OFF 12'h010

// ----------------------------------------------------------------
// system clock control fields
// ----------------------------------------------------------------
`define OSC_SCC_DIV_MSB 7
`define OSC_SCC_DIV_LSB 5
`define OSC_SCC_FHS_BIT 3
`define OSC_SCC_FSS_BIT 2
`define OSC_SCC_FHIDEN_BIT 1
`define OSC_SCC_FSIDEN_BIT 0
`define OSC_SCC_WMASK 8'hEF
`define OSC_SCC_RESET 8'h00
`define OSC_DIV_SLOW 3'h7

// ----------------------------------------------------------------
// fast rc control fields
// ----------------------------------------------------------------
`define OSC_FRC_SEL_MSB 3
`define OSC_FRC_SEL_LSB 2
`define OSC_FRC_RESET 2'h0
`define OSC_FRC_4MHZ 2'h0
`define OSC_FRC_8MHZ 2'h1
`define OSC_FRC_12MHZ 2'h2

// ----------------------------------------------------------------
// slow crystal control fields
// ----------------------------------------------------------------
`define OSC_LXT_SP_BIT 2
`define OSC_LXT_RDY_BIT 1
`define OSC_LXT_EN_BIT 0

// ----------------------------------------------------------------
// status fields
// ----------------------------------------------------------------
`define OSC_ST_HALT_BIT 0
`define OSC_ST_SYSRUN_BIT 1
`define OSC_ST_SUBRUN_BIT 2
`define OSC_ST_LXTUSE_BIT 3
`define OSC_ST_CFGOK_BIT 4

// ----------------------------------------------------------------
// slow crystal start-up times, in us, and cycle counts
// ----------------------------------------------------------------
`define OSC_CLK_MHZ 100
`define OSC_LXT_SPEEDUP_US 10
`define OSC_LXT_LOWPWR_US 20
// counts are the times above at OSC_CLK_MHZ, sized for the 24-bit timer
`define OSC_LXT_SPEEDUP_CYC 24'h0003E8
`define OSC_LXT_LOWPWR_CYC 24'h0007D0
`define OSC_CNT_W 24

`endif

// ---- design/osc_lxt_startup.v ----
/*
 slow crystal start-up timer: counts from enable and raises ready.
 assumes enable and speed-up are register levels on pclk.
*/
`timescale 1ns/1ps
module osc_lxt_startup #(
   parameter [23:0] SPEEDUP_CYC = 24'h0003E8,
   parameter [23:0] LOWPWR_CYC = 24'h0007D0
) (
   input wire pclk,
   input wire presetn,
   input wire enable,
   input wire speedup,
   output reg ready_q
);
   reg [23:0] cnt_q;
   wire [23:0] limit = speedup ? SPEEDUP_CYC : LOWPWR_CYC;

   // ----------------------------------------------------------------
   // counter and ready flag
   // ----------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 24'h000000;
         ready_q <= 1'b0;
      end else if (!enable) begin
         cnt_q <= 24'h000000;
         ready_q <= 1'b0;
      end else if (!ready_q) begin
         if (cnt_q + 24'h000001 >= limit) begin
            ready_q <= 1'b1;
         end
         cnt_q <= cnt_q + 24'h000001;
      end
   end
endmodule // osc_lxt_startup

// ---- design/osc_source_ctrl.v ----
/*
 oscillator source control: apb register file for system clock control,
 fast rc control, slow crystal control and pin sharing, with start-up
 timing and clock source selection.
 assumes apb master on pclk, presetn async active low, halt from the cpu.
*/
// Our own choices: the address map and the APB interface to the registers.
// Overview of operation
// - fast rc frequency fixed by configuration input
// - slow crystal is a slow source choice
// - slow rc is the other slow choice
// - enable bit starts crystal, ready after delay
// - speed-up bit picks low-power or speed-up
// - clearing speed-up keeps crystal running
// - power mode frozen while crystal drives system
// - low-power mode only lengthens start-up
// - unused crystal frees its pins for io
// - halt stops system clock, sub clock optional
// - slow select 0 rc, 1 crystal
// - fast select 0 rc, 1 crystal
`timescale 1ns/1ps
`include "osc_defs.vh"
module osc_source_ctrl (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire [1:0] fast_rc_cfg_freq,
   input wire halt,
   output reg [1:0] fast_rc_freq_q,
   output reg [1:0] sub_src_q,
   output reg [1:0] fast_src_q,
   output reg sys_clk_run_q,
   output reg sub_clk_run_q,
   output reg fast_clk_run_q,
   output reg slow_xtal_osc_en_q,
   output reg slow_xtal_speedup_q,
   output reg slow_xtal_pins_io_q
);
   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   reg [7:0] system_clock_ctrl_reg_q;
   reg [1:0] fast_rc_freq_select_q;
   reg slow_xtal_enable_q;
   reg slow_xtal_speedup_bit_q;
   reg pin_share_io_q;
   reg [1:0] cfg_freq_q;
   wire slow_xtal_ready_flag;
   wire [1:0] sub_src_d;
   wire [1:0] fast_src_d;
   wire sys_run_d;
   wire sub_run_d;
   wire fast_run_d;
   wire lxt_is_sys;
   wire lxt_in_use;
   wire wr_en;
   wire rd_en;
   reg [31:0] rdata_d;
   reg err_d;

   function addr_ok;
      input [11:0] a;
      begin
         addr_ok = (a == `OSC_SYSTEM_CLOCK_CTRL_OFF) || (a == `OSC_FAST_RC_CTRL_OFF) ||
                   (a == `OSC_SLOW_XTAL_CTRL_OFF) || (a == `OSC_PIN_SHARE_OFF) ||
                   (a == `OSC_STATUS_OFF);
      end
   endfunction

   assign wr_en = psel && penable && pwrite && pready;
   assign rd_en = psel && !penable;
   assign lxt_is_sys = (system_clock_ctrl_reg_q[`OSC_SCC_DIV_MSB:`OSC_SCC_DIV_LSB] == `OSC_DIV_SLOW) &&
                       system_clock_ctrl_reg_q[`OSC_SCC_FSS_BIT];
   assign lxt_in_use = slow_xtal_enable_q || system_clock_ctrl_reg_q[`OSC_SCC_FSS_BIT];

   // ----------------------------------------------------------------
   // configuration input capture, every cycle after reset
   // ----------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_freq_q <= `OSC_FRC_4MHZ;
      end else begin
         cfg_freq_q <= fast_rc_cfg_freq;
      end
   end

   // ----------------------------------------------------------------
   // register writes
   // ----------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         system_clock_ctrl_reg_q <= `OSC_SCC_RESET;
         fast_rc_freq_select_q <= `OSC_FRC_RESET;
         slow_xtal_enable_q <= 1'b0;
         slow_xtal_speedup_bit_q <= 1'b0;
         pin_share_io_q <= 1'b0;
      end else if (wr_en) begin
         case (paddr)
            `OSC_SYSTEM_CLOCK_CTRL_OFF: begin
               system_clock_ctrl_reg_q <= pwdata[7:0] & `OSC_SCC_WMASK;
            end
            `OSC_FAST_RC_CTRL_OFF: begin
               fast_rc_freq_select_q <= pwdata[`OSC_FRC_SEL_MSB:`OSC_FRC_SEL_LSB];
            end
            `OSC_SLOW_XTAL_CTRL_OFF: begin
               slow_xtal_enable_q <= pwdata[`OSC_LXT_EN_BIT];
               if (!lxt_is_sys) begin
                  slow_xtal_speedup_bit_q <= pwdata[`OSC_LXT_SP_BIT];
               end
            end
            `OSC_PIN_SHARE_OFF: begin
               pin_share_io_q <= pwdata[0];
            end
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // start-up timer and source selection
   // ----------------------------------------------------------------
   osc_lxt_startup #(
      .SPEEDUP_CYC(`OSC_LXT_SPEEDUP_CYC),
      .LOWPWR_CYC(`OSC_LXT_LOWPWR_CYC)
   ) u_startup (
      .pclk(pclk),
      .presetn(presetn),
      .enable(slow_xtal_enable_q),
      .speedup(slow_xtal_speedup_bit_q),
      .ready_q(slow_xtal_ready_flag)
   );

   osc_clk_mux u_mux (
      .slow_source_select(system_clock_ctrl_reg_q[`OSC_SCC_FSS_BIT]),
      .fast_source_select(system_clock_ctrl_reg_q[`OSC_SCC_FHS_BIT]),
      .div_sel(system_clock_ctrl_reg_q[`OSC_SCC_DIV_MSB:`OSC_SCC_DIV_LSB]),
      .fhiden(system_clock_ctrl_reg_q[`OSC_SCC_FHIDEN_BIT]),
      .fsiden(system_clock_ctrl_reg_q[`OSC_SCC_FSIDEN_BIT]),
      .halt(halt),
      .lxt_ready(slow_xtal_ready_flag),
      .sub_src(sub_src_d),
      .fast_src(fast_src_d),
      .sys_run(sys_run_d),
      .sub_run(sub_run_d),
      .fast_run(fast_run_d)
   );

   // ----------------------------------------------------------------
   // registered outputs
   // ----------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fast_rc_freq_q <= `OSC_FRC_4MHZ;
         sub_src_q <= 2'h1;
         fast_src_q <= 2'h1;
         sys_clk_run_q <= 1'b0;
         sub_clk_run_q <= 1'b0;
         fast_clk_run_q <= 1'b0;
         slow_xtal_osc_en_q <= 1'b0;
         slow_xtal_speedup_q <= 1'b0;
         slow_xtal_pins_io_q <= 1'b0;
      end else begin
         fast_rc_freq_q <= cfg_freq_q;
         sub_src_q <= sub_src_d;
         fast_src_q <= fast_src_d;
         sys_clk_run_q <= sys_run_d;
         sub_clk_run_q <= sub_run_d;
         fast_clk_run_q <= fast_run_d;
         slow_xtal_osc_en_q <= slow_xtal_enable_q;
         slow_xtal_speedup_q <= slow_xtal_speedup_bit_q;
         slow_xtal_pins_io_q <= pin_share_io_q && !lxt_in_use;
      end
   end

   // ----------------------------------------------------------------
   // apb read and answer
   // ----------------------------------------------------------------
   always @* begin
      rdata_d = 32'h00000000;
      err_d = !addr_ok(paddr);
      case (paddr)
         `OSC_SYSTEM_CLOCK_CTRL_OFF: begin
            rdata_d[7:0] = system_clock_ctrl_reg_q;
         end
         `OSC_FAST_RC_CTRL_OFF: begin
            rdata_d[`OSC_FRC_SEL_MSB:`OSC_FRC_SEL_LSB] = fast_rc_freq_select_q;
         end
         `OSC_SLOW_XTAL_CTRL_OFF: begin
            rdata_d[`OSC_LXT_EN_BIT] = slow_xtal_enable_q;
            rdata_d[`OSC_LXT_RDY_BIT] = slow_xtal_ready_flag;
            rdata_d[`OSC_LXT_SP_BIT] = slow_xtal_speedup_bit_q;
         end
         `OSC_PIN_SHARE_OFF: begin
            rdata_d[0] = pin_share_io_q;
         end
         `OSC_STATUS_OFF: begin
            rdata_d[`OSC_ST_HALT_BIT] = halt;
            rdata_d[`OSC_ST_SYSRUN_BIT] = sys_clk_run_q;
            rdata_d[`OSC_ST_SUBRUN_BIT] = sub_clk_run_q;
            rdata_d[`OSC_ST_LXTUSE_BIT] = lxt_in_use;
            rdata_d[`OSC_ST_CFGOK_BIT] = (fast_rc_freq_select_q == cfg_freq_q);
         end
         default: begin
         end
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else if (rd_en) begin
         pready <= 1'b1;
         pslverr <= err_d;
         prdata <= pwrite ? 32'h00000000 : rdata_d;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end
endmodule // osc_source_ctrl

// ---- verif/osc_source_ctrl_checker.sv ----
/*
 port assertions for the oscillator source control block.
 assumes pclk rising edge and presetn async active low; attached by bind.
*/
`timescale 1ns/1ps
module osc_source_ctrl_checker (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pready,
   input wire pslverr,
   input wire [1:0] fast_rc_cfg_freq,
   input wire halt,
   input wire [1:0] fast_rc_freq_q,
   input wire [1:0] sub_src_q,
   input wire [1:0] fast_src_q,
   input wire sys_clk_run_q,
   input wire sub_clk_run_q,
   input wire fast_clk_run_q,
   input wire slow_xtal_osc_en_q,
   input wire slow_xtal_pins_io_q
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ---------------------------------------------
   // apb and clock source assertions
   // ---------------------------------------------
   property p_ready_after_setup; psel && !penable |=> pready; endproperty
   a_ready_after_setup: assert property (p_ready_after_setup) else $error("no pready after setup");
   property p_ready_in_access; pready |-> psel && penable; endproperty
   a_ready_in_access: assert property (p_ready_in_access) else $error("pready outside access");
   property p_ready_pulse; pready |=> !pready; endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
   property p_err_with_ready; pslverr |-> pready; endproperty
   a_err_with_ready: assert property (p_err_with_ready) else $error("pslverr without pready");
   property p_freq_follows; $past(presetn, 2) && $past(presetn) |-> fast_rc_freq_q == $past(fast_rc_cfg_freq, 2); endproperty
   a_freq_follows: assert property (p_freq_follows) else $error("freq copy wrong");
   property p_slow_src; $onehot(sub_src_q); endproperty
   a_slow_src: assert property (p_slow_src) else $error("slow source code bad");
   property p_fast_src; $onehot(fast_src_q); endproperty
   a_fast_src: assert property (p_fast_src) else $error("fast source code bad");
   property p_halt_stops; halt |=> !sys_clk_run_q; endproperty
   a_halt_stops: assert property (p_halt_stops) else $error("system clock runs in halt");
   property p_run_awake; !halt |=> sub_clk_run_q && fast_clk_run_q; endproperty
   a_run_awake: assert property (p_run_awake) else $error("clock stopped while awake");
   property p_pins_busy; slow_xtal_osc_en_q || sub_src_q == 2'b10 |-> !slow_xtal_pins_io_q; endproperty
   a_pins_busy: assert property (p_pins_busy) else $error("crystal pins freed in use");
endmodule // osc_source_ctrl_checker

bind osc_source_ctrl osc_source_ctrl_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pready(pready), .pslverr(pslverr), .fast_rc_cfg_freq(fast_rc_cfg_freq),
   .halt(halt), .fast_rc_freq_q(fast_rc_freq_q), .sub_src_q(sub_src_q), .fast_src_q(fast_src_q),
   .sys_clk_run_q(sys_clk_run_q), .sub_clk_run_q(sub_clk_run_q), .fast_clk_run_q(fast_clk_run_q),
   .slow_xtal_osc_en_q(slow_xtal_osc_en_q), .slow_xtal_pins_io_q(slow_xtal_pins_io_q));

// ---- verif/tb_top.sv ----
/*
 self-checking bench for the oscillator source control block.
 assumes zero-wait apb slave and the default crystal start-up counts.
*/
`timescale 1ns/1ps
module tb_top;
   logic pclk, presetn, psel, penable, pwrite, halt, pready, pslverr, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [1:0] cfg, frq, ssrc, fsrc;
   logic srun, subrun, frun, xen, xsp, pio;
   int fail_count = 0, checks_done = 0, cyc = 0, n;
   // addr, write data, read back, error, {slow src, fast src}
   logic [32:0] rows [0:7] = '{{12'h000, 8'h1F, 8'h0F, 1'b0, 4'hA}, {12'h000, 8'h00, 8'h00, 1'b0, 4'h5},
      {12'h004, 8'h0C, 8'h0C, 1'b0, 4'h5}, {12'h004, 8'h08, 8'h08, 1'b0, 4'h5},
      {12'h00C, 8'h01, 8'h01, 1'b0, 4'h5}, {12'h020, 8'hFF, 8'h00, 1'b1, 4'h5},
      {12'h008, 8'h04, 8'h04, 1'b0, 4'h5}, {12'h008, 8'h00, 8'h00, 1'b0, 4'h5}};
   osc_source_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .fast_rc_cfg_freq(cfg), .halt(halt), .fast_rc_freq_q(frq), .sub_src_q(ssrc), .fast_src_q(fsrc),
      .sys_clk_run_q(srun), .sub_clk_run_q(subrun), .fast_clk_run_q(frun), .slow_xtal_osc_en_q(xen),
      .slow_xtal_speedup_q(xsp), .slow_xtal_pins_io_q(pio));
   // ---------------------------------------------
   // tasks
   // ---------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic [11:0] a, input logic [31:0] d, input logic w);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata; e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 10000) begin
         fail_count++;
         report_and_stop();
      end
   end
   // ---------------------------------------------
   // tests
   // ---------------------------------------------
   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
      cfg = 2'h2; halt = 1'b0;
      repeat (10) @(posedge pclk);
      chk({ssrc, fsrc}, 4'h5);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(12'h000, 32'h0, 1'b0);
      chk(r, 32'h0);
      for (int i = 0; i < 8; i++) begin
         apb(rows[i][32:21], {24'h0, rows[i][20:13]}, 1'b1);
         chk(e, rows[i][4]);
         apb(rows[i][32:21], 32'h0, 1'b0);
         chk(r, {24'h0, rows[i][12:5]});
         chk(e, rows[i][4]);
         repeat (2) @(posedge pclk);
         chk({ssrc, fsrc}, rows[i][3:0]);
      end
      $display("register rows done");
      for (int i = 0; i < 3; i++) begin
         cfg <= i[1:0];
         apb(12'h004, {28'h0, i[1:0], 2'h0}, 1'b1);
         repeat (3) @(posedge pclk);
         apb(12'h010, 32'h0, 1'b0);
         chk(r[4], 1'b1);
         chk(frq, i[1:0]);
      end
      cfg <= 2'h1;
      repeat (3) @(posedge pclk);
      apb(12'h010, 32'h0, 1'b0);
      chk(r[4], 1'b0);
      chk(frq, 2'h1);
      $display("frequency test done");
      apb(12'h000, 32'h01, 1'b1);
      halt <= 1'b1;
      repeat (3) @(posedge pclk);
      chk({srun, subrun, frun}, 3'b010);
      apb(12'h000, 32'h02, 1'b1);
      repeat (2) @(posedge pclk);
      chk({srun, subrun, frun}, 3'b001);
      halt <= 1'b0;
      apb(12'h000, 32'h00, 1'b1);
      chk(pio, 1'b1);
      $display("halt test done");
      apb(12'h008, 32'h05, 1'b1);
      apb(12'h000, 32'hE4, 1'b1);
      apb(12'h008, 32'h01, 1'b1);
      repeat (2) @(posedge pclk);
      chk({xen, xsp, pio, srun}, 4'b1100);
      n = 0;
      while (srun !== 1'b1 && n < 1100) begin
         @(posedge pclk);
         n++;
      end
      chk(n > 980 && n < 1010, 1'b1);
      apb(12'h008, 32'h0, 1'b0);
      chk(r, 32'h07);
      apb(12'h000, 32'h00, 1'b1);
      apb(12'h008, 32'h01, 1'b1);
      apb(12'h008, 32'h0, 1'b0);
      chk(r, 32'h03);
      apb(12'h008, 32'h00, 1'b1);
      repeat (2) @(posedge pclk);
      apb(12'h008, 32'h0, 1'b0);
      chk(r, 32'h00);
      $display("crystal test done");
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      chk({frq, ssrc, fsrc, srun, subrun, frun, xen, xsp, pio}, 12'h140);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(12'h00C, 32'h0, 1'b0);
      chk(r, 32'h0);
      chk({frq, srun, subrun, frun, pio}, 6'h1E);
      apb(12'h000, 32'hE4, 1'b1);
      apb(12'h008, 32'h01, 1'b1);
      n = 0;
      while (srun !== 1'b1 && n < 2100) begin
         @(posedge pclk);
         n++;
      end
      chk(n > 1980 && n < 2010, 1'b1);
      apb(12'h008, 32'h0, 1'b0);
      chk(r, 32'h03);
      $display("reset and low-power test done");
      report_and_stop();
   end
endmodule // tb_top
